//--- src/pcb_dma_regs.sv
// DMA configuration registers at 40h-4ch
`timescale 1ns/1ps
`include "pcb_regs.svh"
module pcb_dma_regs
  import pcb_pkg::*;
(
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic cfg_wr_i, // Config write strobe
  input wire logic [7:0] cfg_addr_i, // Config byte address
  input wire logic [31:0] cfg_wdata_i, // Config write data
  input wire logic dma_done_i, // Transfer finished pulse
  output pcb_dma_t dma_o, // Register state
  output logic [31:0] cfg_rdata_o // Read data, one cycle later
);

  pcb_dma_t dma;
  pcb_dma_t next_dma;
  logic [31:0] next_rdata;

  always_comb begin
    next_dma = dma;
    next_dma.start = 1'b0;
    if (cfg_wr_i) begin
      case (cfg_addr_i)
        `PCB_OFS_PCI_ADDR: next_dma.pci_addr = cfg_wdata_i;
        `PCB_OFS_LOCAL_ADDR: next_dma.local_addr = cfg_wdata_i;
        `PCB_OFS_CTRL: begin
          next_dma.ie = cfg_wdata_i[`PCB_CTRL_IE];
          next_dma.dir = cfg_wdata_i[`PCB_CTRL_DIR];
          next_dma.len_field = cfg_wdata_i[`PCB_CTRL_LEN_HI:`PCB_CTRL_LEN_LO];
          // Lengths above 1024 are illegal; only the low bits are used
          next_dma.len_dwords = (next_dma.len_field == 12'h000) ? `PCB_LEN_MAX :
                                next_dma.len_field[10:0];
          if (cfg_wdata_i[`PCB_CTRL_DONE]) begin
            next_dma.done = 1'b0;
          end
          if (cfg_wdata_i[`PCB_CTRL_START]) begin
            next_dma.start = 1'b1;
            next_dma.done = 1'b0;
          end
        end
        `PCB_OFS_LATENCY: next_dma.latency = cfg_wdata_i[2:0];
        default: ;
      endcase
    end
    // Completion wins over a clear in the same cycle
    if (dma_done_i) begin
      next_dma.done = 1'b1;
    end
  end

  always_comb begin
    next_rdata = `PCB_RST_WORD;
    case (cfg_addr_i)
      `PCB_OFS_PCI_ADDR: next_rdata = dma.pci_addr;
      `PCB_OFS_LOCAL_ADDR: next_rdata = dma.local_addr;
      `PCB_OFS_CTRL: begin
        next_rdata[`PCB_CTRL_LEN_HI:`PCB_CTRL_LEN_LO] = dma.len_field;
        next_rdata[`PCB_CTRL_IE] = dma.ie;
        next_rdata[`PCB_CTRL_DIR] = dma.dir;
        next_rdata[`PCB_CTRL_DONE] = dma.done;
      end
      `PCB_OFS_LATENCY: next_rdata[2:0] = dma.latency;
      default: ;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dma <= '0;
      cfg_rdata_o <= `PCB_RST_WORD;
    end else begin
      dma <= next_dma;
      cfg_rdata_o <= next_rdata;
    end
  end

  assign dma_o = dma;

endmodule : pcb_dma_regs

//--- src/pcb_pkg.sv
// Types shared by the target back-end flow control and its registers
package pcb_pkg;

  typedef enum logic [1:0] {PCB_IDLE, PCB_DATA, PCB_STOP} pcb_state_t;

  typedef struct packed {
    logic trdy_n;
    logic stop_n;
    logic devsel_n;
    logic oe;
  } pcb_tgt_t;

  typedef struct packed {
    logic [31:0] pci_addr;
    logic [31:0] local_addr;
    logic [11:0] len_field;
    logic [10:0] len_dwords;
    logic dir;
    logic ie;
    logic done;
    logic start;
    logic [2:0] latency;
  } pcb_dma_t;

endpackage : pcb_pkg

//--- src/pcb_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PCB_REGS_SVH
`define PCB_REGS_SVH
// Overview of operation
// - Write-ready drives TRDYn; lane strobes follow
// - Read-ready pulses read strobe; TRDYn next
// - IRDYn wait drops strobes one cycle later
// - Write-ready dropped mid-burst deasserts TRDYn next cycle
// - Read-ready drop ends strobe, then TRDYn
// - Latency zero: data valid with address
// - Latency N: data valid N cycles later
// - Back-end error: STOPn on, DEVSELn off
// - Grant active at access start: retry
// - Back-end stall: disconnect without data
// - Grant local bus when target idle
// - Request dropped: grant drops next cycle
// - Sample external interrupt, assert INTAn next
// - Two 32-bit DMA start address registers
// - Length in bits 27:16, zero means 1024
// - Bit 7 interrupt enable, 3 direction, 4 start
// - Completion sets bit 1, raises interrupt

// ****************************************************************
// Register offsets
// ****************************************************************
`define PCB_OFS_PCI_ADDR 8'h40
`define PCB_OFS_LOCAL_ADDR 8'h44
`define PCB_OFS_CTRL 8'h48
`define PCB_OFS_LATENCY 8'h4c

// ****************************************************************
// Control register fields
// ****************************************************************
`define PCB_CTRL_IE 7
`define PCB_CTRL_START 4
`define PCB_CTRL_DIR 3
`define PCB_CTRL_DONE 1
`define PCB_CTRL_LEN_HI 27
`define PCB_CTRL_LEN_LO 16
`define PCB_LEN_MAX 11'h400
`define PCB_RST_WORD 32'h0000_0000

// ****************************************************************
// Timing
// ****************************************************************
`define PCB_STALL_LIMIT 4'h6
`endif

//--- src/pcb_target.sv
// PCI target back-end flow control, local-bus arbitration and interrupt
`timescale 1ns/1ps
`include "pcb_regs.svh"
module pcb_target
  import pcb_pkg::*;
(
  input wire logic mclk_i, // PCI clock
  input wire logic rst_i, // Sync reset
  input wire logic frame_n_i, // PCI FRAMEn
  input wire logic irdy_n_i, // PCI IRDYn
  input wire logic [31:0] ad_i, // PCI AD in
  input wire logic [3:0] cbe_n_i, // PCI byte enables
  input wire logic hit_i, // Address decode hit, one cycle
  input wire logic hit_read_i, // Hit is a read
  output logic trdy_n_o, // PCI TRDYn
  output logic stop_n_o, // PCI STOPn
  output logic devsel_n_o, // PCI DEVSELn
  output logic ctl_oe_o, // Enable for TRDYn/STOPn/DEVSELn
  output logic [31:0] ad_o, // PCI AD out
  output logic ad_oe_o, // AD drive enable
  input wire logic cfg_wr_i, // Config write
  input wire logic [7:0] cfg_addr_i, // Config address
  input wire logic [31:0] cfg_wdata_i, // Config write data
  output logic [31:0] cfg_rdata_o, // Config read data
  input wire logic backend_write_ready_i, // Back-end write ready
  input wire logic backend_read_ready_i, // Back-end read ready
  input wire logic backend_error_i, // Back-end error
  input wire logic [31:0] be_rdata_i, // Back-end read data
  output logic [3:0] write_lane_strobe_o, // Write lane strobes
  output logic read_data_strobe_o, // Read data strobe
  output logic [31:0] be_wdata_o, // Back-end write data
  output logic [31:0] be_addr_o, // Back-end byte address
  output logic [2:0] address_data_latency_o, // Latency setting
  input wire logic local_bus_request_i, // Local bus request
  output logic local_bus_grant_o, // Local bus grant
  input wire logic external_interrupt_n_i, // External interrupt
  output logic inta_n_o, // INTAn level
  output logic inta_oe_o, // INTAn open-drain enable
  input wire logic dma_done_i, // DMA engine finished
  output logic dma_start_o, // DMA start pulse
  output logic dma_dir_o, // DMA direction
  output logic [10:0] dma_len_o, // DMA length in DWORDs
  output logic [31:0] dma_pci_addr_o, // DMA PCI start
  output logic [31:0] dma_local_addr_o // DMA local start
);

  localparam pcb_tgt_t TGT_OFF = '{trdy_n: 1'b1, stop_n: 1'b1, devsel_n: 1'b1, oe: 1'b0};

  function automatic logic xfer(input logic trdy_n, input logic irdy_n);
    xfer = ~trdy_n & ~irdy_n;
  endfunction : xfer

  pcb_dma_t dma;
  pcb_state_t state;
  pcb_state_t next_state;
  pcb_tgt_t tgt;
  pcb_tgt_t next_tgt;
  logic [3:0] wait_cnt;
  logic [3:0] next_wait_cnt;
  logic rd_mode;
  logic next_rd_mode;
  logic [31:0] be_addr;
  logic [31:0] next_be_addr;
  logic [3:0] wstrobe;
  logic [3:0] next_wstrobe;
  logic rstrobe;
  logic next_rstrobe;
  logic [31:0] wdata;
  logic [31:0] next_wdata;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic rdata_oe;
  logic next_rdata_oe;
  logic grant;
  logic next_grant;
  logic inta_n;
  logic next_inta_n;
  logic inta_oe;
  logic [7:0] strb_dly;
  logic capture;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  pcb_dma_regs pcb_dma_regs_inst (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .cfg_wr_i(cfg_wr_i),
    .cfg_addr_i(cfg_addr_i),
    .cfg_wdata_i(cfg_wdata_i),
    .dma_done_i(dma_done_i),
    .dma_o(dma),
    .cfg_rdata_o(cfg_rdata_o)
  );

  // ****************************************************************
  // Read capture delay line
  // ****************************************************************
  assign strb_dly[0] = rstrobe;
  genvar k;
  generate
    for (k = 1; k < 8; k++) begin : g_dly
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          strb_dly[k] <= 1'b0;
        end else begin
          strb_dly[k] <= strb_dly[k-1];
        end
      end
    end
  endgenerate
  // Data is taken N cycles after its strobe
  assign capture = strb_dly[dma.latency];

  // ****************************************************************
  // Target state machine
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_tgt = tgt;
    next_wait_cnt = wait_cnt;
    next_rd_mode = rd_mode;
    next_be_addr = be_addr;
    if (rstrobe || (wstrobe != 4'h0)) begin
      next_be_addr = be_addr + 32'h0000_0004;
    end
    case (state)
      PCB_IDLE: begin
        next_tgt = TGT_OFF;
        if (hit_i) begin
          next_rd_mode = hit_read_i;
          next_be_addr = ad_i;
          next_wait_cnt = 4'h0;
          next_tgt.oe = 1'b1;
          next_tgt.devsel_n = 1'b0;
          if (grant) begin
            next_tgt.stop_n = 1'b0;
            next_state = PCB_STOP;
          end else begin
            next_state = PCB_DATA;
          end
        end
      end
      PCB_DATA: begin
        if (backend_error_i) begin
          next_tgt.stop_n = 1'b0;
          next_tgt.devsel_n = 1'b1;
          next_tgt.trdy_n = 1'b1;
          next_state = PCB_STOP;
        end else if (frame_n_i && xfer(tgt.trdy_n, irdy_n_i)) begin
          // Drive deasserted one cycle before release
          next_tgt.trdy_n = 1'b1;
          next_tgt.devsel_n = 1'b1;
          next_state = PCB_IDLE;
        end else if (wait_cnt == `PCB_STALL_LIMIT) begin
          next_tgt.stop_n = 1'b0;
          next_tgt.trdy_n = 1'b1;
          next_state = PCB_STOP;
        end else begin
          // A word already offered is held until the master takes it
          if (rd_mode) begin
            next_tgt.trdy_n = ~(capture | (~tgt.trdy_n & irdy_n_i));
          end else begin
            next_tgt.trdy_n = ~(backend_write_ready_i |
                                (~tgt.trdy_n & irdy_n_i));
          end
          next_wait_cnt = tgt.trdy_n ? wait_cnt + 4'h1 : 4'h0;
        end
      end
      PCB_STOP: begin
        if (frame_n_i) begin
          next_tgt = TGT_OFF;
          next_tgt.oe = 1'b1;
          next_state = PCB_IDLE;
        end
      end
      default: begin
        next_tgt = TGT_OFF;
        next_state = PCB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= PCB_IDLE;
      tgt <= TGT_OFF;
      wait_cnt <= 4'h0;
      rd_mode <= 1'b0;
      be_addr <= `PCB_RST_WORD;
    end else begin
      state <= next_state;
      tgt <= next_tgt;
      wait_cnt <= next_wait_cnt;
      rd_mode <= next_rd_mode;
      be_addr <= next_be_addr;
    end
  end

  // ****************************************************************
  // Back-end data path
  // ****************************************************************
  always_comb begin
    next_wstrobe = 4'h0;
    next_wdata = wdata;
    next_rdata = rdata;
    // Strobes follow IRDYn with one cycle of lag
    if ((state == PCB_DATA) && !rd_mode && xfer(tgt.trdy_n, irdy_n_i)) begin
      next_wstrobe = ~cbe_n_i;
      next_wdata = ad_i;
    end
    next_rstrobe = (state == PCB_DATA) && rd_mode && backend_read_ready_i &&
                   !irdy_n_i && !backend_error_i && !frame_n_i;
    if (capture) begin
      next_rdata = be_rdata_i;
    end
    next_rdata_oe = (next_state == PCB_DATA) && next_rd_mode;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wstrobe <= 4'h0;
      rstrobe <= 1'b0;
      wdata <= `PCB_RST_WORD;
      rdata <= `PCB_RST_WORD;
      rdata_oe <= 1'b0;
    end else begin
      wstrobe <= next_wstrobe;
      rstrobe <= next_rstrobe;
      wdata <= next_wdata;
      rdata <= next_rdata;
      rdata_oe <= next_rdata_oe;
    end
  end

  // ****************************************************************
  // Local bus arbitration and interrupt
  // ****************************************************************
  always_comb begin
    // No grant in the cycle a hit arrives, so an access never meets a fresh grant
    next_grant = local_bus_request_i &&
                 (grant || ((state == PCB_IDLE) && !hit_i));
    next_inta_n = external_interrupt_n_i && !(dma.done && dma.ie);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      grant <= 1'b0;
      inta_n <= 1'b1;
      inta_oe <= 1'b0;
    end else begin
      grant <= next_grant;
      inta_n <= next_inta_n;
      inta_oe <= ~next_inta_n;
    end
  end

  assign trdy_n_o = tgt.trdy_n;
  assign stop_n_o = tgt.stop_n;
  assign devsel_n_o = tgt.devsel_n;
  assign ctl_oe_o = tgt.oe;
  assign ad_o = rdata;
  assign ad_oe_o = rdata_oe;
  assign write_lane_strobe_o = wstrobe;
  assign read_data_strobe_o = rstrobe;
  assign be_wdata_o = wdata;
  assign be_addr_o = be_addr;
  assign address_data_latency_o = dma.latency;
  assign local_bus_grant_o = grant;
  assign inta_n_o = inta_n;
  assign inta_oe_o = inta_oe;
  assign dma_start_o = dma.start;
  assign dma_dir_o = dma.dir;
  assign dma_len_o = dma.len_dwords;
  assign dma_pci_addr_o = dma.pci_addr;
  assign dma_local_addr_o = dma.local_addr;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_wr_trdy;
    (state == PCB_DATA) && !rd_mode && backend_write_ready_i && !backend_error_i &&
    !frame_n_i && (wait_cnt != `PCB_STALL_LIMIT) |=> !trdy_n_o;
  endproperty
  a_wr_trdy: assert property (p_wr_trdy) else $error("write ready did not give TRDYn");

  property p_wr_lanes;
    (state == PCB_DATA) && !rd_mode && !trdy_n_o && !irdy_n_i
    |=> write_lane_strobe_o == ~$past(cbe_n_i);
  endproperty
  a_wr_lanes: assert property (p_wr_lanes) else $error("lane strobes wrong");

  property p_irdy_wait;
    irdy_n_i |=> (write_lane_strobe_o == 4'h0) && !read_data_strobe_o;
  endproperty
  a_irdy_wait: assert property (p_irdy_wait) else $error("strobe during IRDYn wait");

  property p_rd_trdy;
    read_data_strobe_o && (address_data_latency_o == 3'h0) && (state == PCB_DATA) &&
    !backend_error_i && (wait_cnt != `PCB_STALL_LIMIT) && !frame_n_i |=> !trdy_n_o;
  endproperty
  a_rd_trdy: assert property (p_rd_trdy) else $error("read strobe not followed by TRDYn");

  property p_rd_drop;
    !backend_read_ready_i |=> !read_data_strobe_o;
  endproperty
  a_rd_drop: assert property (p_rd_drop) else $error("read strobe after ready drop");

  property p_abort;
    (state == PCB_DATA) && backend_error_i |=> !stop_n_o && devsel_n_o && trdy_n_o;
  endproperty
  a_abort: assert property (p_abort) else $error("no target abort on error");

  property p_retry;
    (state == PCB_IDLE) && hit_i && local_bus_grant_o |=> !stop_n_o && !devsel_n_o && trdy_n_o;
  endproperty
  a_retry: assert property (p_retry) else $error("no retry with grant");

  property p_stall;
    (state == PCB_DATA) && (wait_cnt == `PCB_STALL_LIMIT) && !backend_error_i &&
    !(frame_n_i && !trdy_n_o && !irdy_n_i) |=> !stop_n_o && trdy_n_o;
  endproperty
  a_stall: assert property (p_stall) else $error("no disconnect after stall");

  property p_grant_drop;
    !local_bus_request_i |=> !local_bus_grant_o;
  endproperty
  a_grant_drop: assert property (p_grant_drop) else $error("grant held after request");

  property p_grant_idle;
    local_bus_request_i && (state == PCB_IDLE) && !hit_i |=> local_bus_grant_o;
  endproperty
  a_grant_idle: assert property (p_grant_idle) else $error("no grant at idle");

  property p_int;
    !external_interrupt_n_i |=> !inta_n_o && inta_oe_o;
  endproperty
  a_int: assert property (p_int) else $error("INTAn not asserted");

  c_write: cover property (!write_lane_strobe_o[0] ##1 write_lane_strobe_o[0]);
  c_read: cover property (read_data_strobe_o ##1 !trdy_n_o);
  c_abort: cover property (!stop_n_o && devsel_n_o);
  c_retry: cover property ((state == PCB_STOP) && !devsel_n_o && (wait_cnt == 4'h0));

endmodule : pcb_target

//--- verification/pcb_backend_model.sv
// Back-end memory model that answers the target's strobes
`timescale 1ns/1ps
module pcb_backend_model (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic ready_i, // Bench wants the back-end ready
  input wire logic error_i, // Bench wants an error
  input wire logic rd_strobe_i, // Read data strobe
  input wire logic [31:0] addr_i, // Back-end byte address
  input wire logic [2:0] latency_i, // Address-data latency
  output logic write_ready_o, // Write ready
  output logic read_ready_o, // Read ready
  output logic error_o, // Error
  output logic [31:0] rdata_o // Read data
);
  logic rdy_q;
  logic [32:0] pipe [8];
  logic [31:0] last;
  logic [32:0] tap;

  // ****************************************************************
  // Ready, error and data pipe
  // ****************************************************************
  // Ready and error follow the bench one cycle later; written words are not stored
  always_ff @(posedge mclk_i) begin
    rdy_q <= rst_i ? 1'b0 : ready_i;
    error_o <= rst_i ? 1'b0 : error_i;
    pipe[0] <= {rd_strobe_i & ~rst_i, 16'ha5c3, addr_i[15:0]};
    for (int i = 1; i < 8; i++) begin
      pipe[i] <= pipe[i-1];
    end
    last <= rst_i ? 32'h0 : rdata_o;
  end

  assign write_ready_o = rdy_q & ~error_o;
  assign read_ready_o = rdy_q & ~error_o;

  // Data outside its valid slot is scrambled, never the last word
  always_comb begin
    tap = (latency_i == 3'h0) ? {rd_strobe_i, 16'ha5c3, addr_i[15:0]}
      : pipe[latency_i - 3'h1];
    rdata_o = tap[32] ? tap[31:0] : ~last;
  end
endmodule : pcb_backend_model

//--- verification/test_pcb_target.sv
// Self-checking bench for the target back-end flow control
`timescale 1ns/1ps
module test_pcb_target;
  logic mclk_i, rst_i, frame_n_i, irdy_n_i, hit_i, hit_read_i, cfg_wr_i;
  logic [31:0] ad_i, cfg_wdata_i, be_rdata_i, cfg_rdata_o, ad_o, be_wdata_o, be_addr_o;
  logic [31:0] dma_pci_addr_o, dma_local_addr_o;
  logic [3:0] cbe_n_i, write_lane_strobe_o;
  logic [7:0] cfg_addr_i;
  logic [2:0] address_data_latency_o;
  logic [10:0] dma_len_o;
  logic backend_write_ready_i, backend_read_ready_i, backend_error_i, local_bus_request_i;
  logic external_interrupt_n_i, dma_done_i, trdy_n_o, stop_n_o, devsel_n_o, ctl_oe_o;
  logic ad_oe_o, read_data_strobe_o, local_bus_grant_o, inta_n_o, inta_oe_o;
  logic dma_start_o, dma_dir_o, ready, error, stopped, trdy_seen, abort_seen, retry_seen;
  logic [31:0] wq [$];
  logic [31:0] aq [$];
  logic [31:0] rq [$];
  int n_mismatch = 0;
  int n_tests = 0;
  int starts = 0;
  int strobes = 0;
  int got = 0;
  int drop_at = 99;
  int wait_at = 99;

  pcb_target pcb_target_inst (.mclk_i, .rst_i, .frame_n_i, .irdy_n_i, .ad_i, .cbe_n_i,
    .hit_i, .hit_read_i, .trdy_n_o, .stop_n_o, .devsel_n_o, .ctl_oe_o, .ad_o, .ad_oe_o,
    .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .backend_write_ready_i,
    .backend_read_ready_i, .backend_error_i, .be_rdata_i, .write_lane_strobe_o,
    .read_data_strobe_o, .be_wdata_o, .be_addr_o, .address_data_latency_o,
    .local_bus_request_i, .local_bus_grant_o, .external_interrupt_n_i, .inta_n_o,
    .inta_oe_o, .dma_done_i, .dma_start_o, .dma_dir_o, .dma_len_o, .dma_pci_addr_o,
    .dma_local_addr_o);

  pcb_backend_model pcb_backend_model_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .ready_i(ready), .error_i(error), .rd_strobe_i(read_data_strobe_o),
    .addr_i(be_addr_o), .latency_i(address_data_latency_o),
    .write_ready_o(backend_write_ready_i), .read_ready_o(backend_read_ready_i),
    .error_o(backend_error_i), .rdata_o(be_rdata_i));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // ****************************************************************
  // Monitors
  // ****************************************************************
  always @(posedge mclk_i) begin
    if (dma_start_o === 1'b1) starts++;
    if (rst_i === 1'b0 && write_lane_strobe_o !== 4'h0) begin
      strobes++;
      wq.push_back(be_wdata_o);
      aq.push_back(be_addr_o);
      chk_word({28'h0, write_lane_strobe_o}, 32'ha, "lanes");
    end
    if (ctl_oe_o === 1'b1 && trdy_n_o === 1'b0) trdy_seen = 1'b1;
    if (ctl_oe_o === 1'b1 && trdy_n_o === 1'b0) chk_bit(ad_oe_o, hit_read_i, "ad drive");
    if (ctl_oe_o === 1'b1 && stop_n_o === 1'b0 && devsel_n_o === 1'b1) abort_seen = 1'b1;
    if (ctl_oe_o === 1'b1 && stop_n_o === 1'b0 && devsel_n_o === 1'b0) retry_seen = 1'b1;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic step;
    @(posedge mclk_i);
    #1;
  endtask : step

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_word

  task automatic chk_bit(input logic g, input logic e, input string m);
    chk_word({31'h0, g}, {31'h0, e}, m);
  endtask : chk_bit

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
    cfg_wr_i = 1'b1;
    cfg_addr_i = a;
    cfg_wdata_i = d;
    step();
    cfg_wr_i = 1'b0;
    step();
  endtask : cfg_write

  task automatic cfg_expect(input logic [7:0] a, input logic [31:0] e);
    cfg_addr_i = a;
    step();
    chk_word(cfg_rdata_o, e, "cfg read");
  endtask : cfg_expect

  // PCI master: hit, then data phases until n words, a stop, or the bound
  task automatic pci_xfer(input logic rd_op, input int n, input logic [31:0] addr);
    logic cmp;
    logic fin;
    logic [31:0] cap;
    int wt;
    cmp = 1'b0;
    fin = 1'b0;
    wt = 0;
    got = 0;
    stopped = 1'b0;
    strobes = 0;
    rq.delete();
    wq.delete();
    aq.delete();
    trdy_seen = 1'b0;
    abort_seen = 1'b0;
    retry_seen = 1'b0;
    hit_i = 1'b1;
    hit_read_i = rd_op;
    ad_i = addr;
    frame_n_i = 1'b0;
    step();
    hit_i = 1'b0;
    irdy_n_i = 1'b0;
    ad_i = 32'hc0de_0000;
    for (int c = 0; c < 40 && !fin; c++) begin
      step();
      if (cmp) begin
        got++;
        rq.push_back(cap);
        if (got == drop_at) ready = 1'b0;
        if (got == wait_at) wt = 2;
      end
      if (stopped || got == n) fin = 1'b1;
      if (stop_n_o === 1'b0) stopped = 1'b1;
      frame_n_i = (stopped || got >= n - 1) ? 1'b1 : 1'b0;
      irdy_n_i = (wt > 0 || fin) ? 1'b1 : 1'b0;
      if (wt > 0) wt--;
      ad_i = {16'hc0de, got[15:0]};
      cmp = !fin && trdy_n_o === 1'b0 && irdy_n_i === 1'b0;
      cap = ad_o;
    end
    for (int c = 0; c < 10 && ctl_oe_o !== 1'b0; c++) step();
    if (!fin || ctl_oe_o !== 1'b0) begin
      n_mismatch++;
      $display("FAIL %0t transfer hung", $time);
      complete_run();
    end
    step();
  endtask : pci_xfer

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sc_regs;
    logic [7:0] ofs [5] = '{8'h40, 8'h44, 8'h48, 8'h4c, 8'h50};
    foreach (ofs[i]) cfg_expect(ofs[i], 32'h0);
    cfg_write(8'h40, 32'h1234_5678);
    cfg_write(8'h44, 32'h9abc_def0);
    cfg_write(8'h50, 32'hffff_ffff);
    cfg_expect(8'h40, 32'h1234_5678);
    cfg_expect(8'h44, 32'h9abc_def0);
    cfg_expect(8'h50, 32'h0);
    chk_word(dma_pci_addr_o, 32'h1234_5678, "pci addr");
    chk_word(dma_local_addr_o, 32'h9abc_def0, "local addr");
    cfg_write(8'h48, 32'h0000_0088);
    step();
    chk_word({21'h0, dma_len_o}, 32'h400, "len zero");
    chk_bit(dma_dir_o, 1'b1, "dir");
    starts = 0;
    cfg_write(8'h48, 32'h0004_0098);
    step();
    step();
    chk_word(starts, 32'h1, "start pulses");
    cfg_expect(8'h48, 32'h0004_0088);
    chk_word({21'h0, dma_len_o}, 32'h4, "len four");
    dma_done_i = 1'b1;
    step();
    dma_done_i = 1'b0;
    step();
    step();
    cfg_expect(8'h48, 32'h0004_008a);
    chk_bit(inta_n_o, 1'b0, "done irq");
    cfg_write(8'h48, 32'h0004_0002);
    step();
    step();
    cfg_expect(8'h48, 32'h0004_0000);
    chk_bit(inta_n_o, 1'b1, "irq off");
  endtask : sc_regs

  task automatic sc_write;
    wait_at = 1;
    pci_xfer(1'b0, 4, 32'h0000_1000);
    wait_at = 99;
    chk_word(got, 32'h4, "write words");
    chk_word(strobes, 32'h4, "strobe count");
    foreach (wq[i]) chk_word(wq[i], {16'hc0de, 16'(i)}, "wdata");
    foreach (aq[i]) chk_word(aq[i], 32'h1000 + 32'(4 * i), "waddr");
  endtask : sc_write

  task automatic sc_read(input logic [2:0] lat);
    cfg_write(8'h4c, {29'h0, lat});
    step();
    chk_word({29'h0, address_data_latency_o}, {29'h0, lat}, "latency");
    pci_xfer(1'b1, 3, 32'h0000_2000);
    chk_word(got, 32'h3, "read words");
    foreach (rq[i]) chk_word(rq[i], {16'ha5c3, 16'h2000 + 16'(4 * i)}, "rdata");
  endtask : sc_read

  task automatic sc_stall;
    drop_at = 1;
    pci_xfer(1'b0, 8, 32'h0000_3000);
    drop_at = 99;
    ready = 1'b1;
    chk_bit(stopped, 1'b1, "disconnect");
    chk_bit(got >= 1 && got <= 3, 1'b1, "words after drop");
    chk_word(strobes, got, "stall strobes");
  endtask : sc_stall

  task automatic sc_abort;
    ready = 1'b0;
    error = 1'b1;
    pci_xfer(1'b1, 2, 32'h0000_4000);
    error = 1'b0;
    ready = 1'b1;
    chk_bit(abort_seen, 1'b1, "abort");
    chk_bit(trdy_seen, 1'b0, "abort trdy");
  endtask : sc_abort

  task automatic sc_retry;
    local_bus_request_i = 1'b1;
    step();
    chk_bit(local_bus_grant_o, 1'b1, "grant");
    pci_xfer(1'b0, 2, 32'h0000_5000);
    chk_bit(retry_seen, 1'b1, "retry");
    chk_bit(trdy_seen, 1'b0, "retry trdy");
    chk_bit(local_bus_grant_o, 1'b1, "grant held");
    local_bus_request_i = 1'b0;
    step();
    chk_bit(local_bus_grant_o, 1'b0, "grant drop");
  endtask : sc_retry

  task automatic sc_intr;
    external_interrupt_n_i = 1'b0;
    chk_bit(inta_n_o, 1'b1, "inta idle");
    step();
    chk_bit(inta_n_o, 1'b0, "inta");
    chk_bit(inta_oe_o, 1'b1, "inta oe");
    external_interrupt_n_i = 1'b1;
    step();
    step();
    chk_bit(inta_n_o, 1'b1, "inta off");
  endtask : sc_intr

  initial begin
    rst_i = 1'b1;
    {frame_n_i, irdy_n_i, external_interrupt_n_i, ready} = 4'hf;
    {hit_i, hit_read_i, cfg_wr_i, local_bus_request_i, dma_done_i, error} = 6'h0;
    ad_i = 32'h0;
    cfg_wdata_i = 32'h0;
    cfg_addr_i = 8'h0;
    cbe_n_i = 4'h5;
    repeat (10) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    sc_regs();
    sc_write();
    sc_read(3'h0);
    sc_read(3'h1);
    sc_stall();
    sc_abort();
    sc_retry();
    sc_intr();
    complete_run();
  end
endmodule : test_pcb_target
